// ### itr_consts.vh
`ifndef ITR_CONSTS_VH
`define ITR_CONSTS_VH
// ****************************************
// register byte addresses (even = high byte)
// ****************************************
`define ITR_ADDR_W          23
`define ITR_PAL_GB_ADDR     23'h7fff7e
`define ITR_PAL_R_ADDR      23'h7fff7f
`define ITR_BANK_ADDR       23'h7fffc0
`define ITR_X_ADDR          23'h7fffc2
`define ITR_Y_ADDR          23'h7fffc4
`define ITR_FA_HI_ADDR      23'h7fffc6
`define ITR_FA_LO_ADDR      23'h7fffc8
`define ITR_W_ADDR          23'h7fffca
`define ITR_LINES_ADDR      23'h7fffcc
`define ITR_CTRL_ADDR       23'h7fffce
// ****************************************
// field positions and reset values
// ****************************************
`define ITR_BANK_HI         5
`define ITR_BANK_LO         3
`define ITR_GO_BIT          0
`define ITR_X_W             11
`define ITR_Y_W             10
`define ITR_FA_W            25
`define ITR_PW_W            12
`define ITR_LC_W            11
`define ITR_RESET_BYTE      8'h00
// ****************************************
// timing
// ****************************************
`define ITR_CLK_HZ          10000000
`define ITR_PULSE_NS        1000
`define ITR_PULSE_CYC       ((`ITR_PULSE_NS * (`ITR_CLK_HZ / 1000000)) / 1000)
`endif

// ### itr_setup_regs.v
`timescale 1ns/100ps
`include "itr_consts.vh"

// Function
// - last palette entry: even GB, odd R
// - bank bits 5..3 drive upper flash address
// - word write takes bank from high byte
// - start X: 11 bits, reset zero
// - start Y: 10 bits, reset zero
// - no range checks or clamping anywhere
// - flash start address 25 bits, reset zero
// - width: 12 bits, reset zero
// - byte and word writes both accepted
// - line count: 11 bits, reset zero
// - writing go starts transfer, self clears
// - request bus, wait for grant
// - release request, 1 us low done pulse
module itr_setup_regs #(
	parameter PULSE_CYC = `ITR_PULSE_CYC
) (
	input  wire                    clk,
	input  wire                    resetn,
	input  wire [`ITR_ADDR_W-1:0]  cpu_addr,
	input  wire [15:0]             cpu_wdata,
	input  wire                    cpu_wr,
	input  wire                    cpu_word,
	input  wire                    bus_grant,
	input  wire                    xfer_done,
	output reg  [3:0]              green_nibble,
	output reg  [3:0]              blue_nibble,
	output reg  [3:0]              red_nibble,
	output reg                     bank_out_top,
	output reg                     bank_out_mid,
	output reg                     bank_out_low,
	output reg  [`ITR_X_W-1:0]     image_start_x,
	output reg  [`ITR_Y_W-1:0]     image_start_y,
	output reg  [`ITR_FA_W-1:0]    flash_start_address,
	output reg  [`ITR_PW_W-1:0]    image_pixel_width,
	output reg  [`ITR_LC_W-1:0]    image_line_count,
	output reg                     transfer_go,
	output reg                     bus_req,
	output reg                     xfer_run,
	output reg                     done_irq_out_n
);

	// ****************************************
	// handshake states
	// ****************************************
	// idle: waiting for a go write from the cpu
	localparam ST_IDLE = 2'd0;
	// req: bus requested, cpu still owns the external bus
	localparam ST_REQ  = 2'd1;
	// run: bus granted, the transfer engine is moving data
	localparam ST_RUN  = 2'd2;
	// done: bus handed back, completion pulse is low
	localparam ST_DONE = 2'd3;

	// ****************************************
	// internal state
	// ****************************************
	// state of the bus handshake
	reg [1:0]  state_reg;
	// remaining low cycles of the completion pulse; 16 bits covers
	// any sensible clock rate for a pulse of about one microsecond
	reg [15:0] pulse_reg;
	// go bit as the cpu would see it: set by the write, cleared at start
	reg        go_reg;

	// ****************************************
	// write lane decode
	// ****************************************
	// even lane: word or byte access at the even base address only
	function hi_hit;
		input [`ITR_ADDR_W-1:0] a;
		input [`ITR_ADDR_W-1:0] base;
		begin
			hi_hit = cpu_wr && (a == base);
		end
	endfunction

	// odd lane: word access at even base, or a byte at base plus one;
	// a word aimed at the odd address hits neither lane and is dropped
	function lo_hit;
		input [`ITR_ADDR_W-1:0] a;
		input [`ITR_ADDR_W-1:0] base;
		begin
			lo_hit = cpu_wr && ((cpu_word && a == base) ||
				(!cpu_word && a == (base | 23'h000001)));
		end
	endfunction

	// byte writes carry the lane value in the low data byte; words split
	wire [7:0] hi_byte = cpu_word ? cpu_wdata[15:8] : cpu_wdata[7:0];
	wire [7:0] lo_byte = cpu_wdata[7:0];

	// ****************************************
	// setup registers
	// ****************************************
	// values stored as written; software owns range
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			green_nibble        <= 4'h0;
			blue_nibble         <= 4'h0;
			red_nibble          <= 4'h0;
			bank_out_top        <= 1'b0;
			bank_out_mid        <= 1'b0;
			bank_out_low        <= 1'b0;
			image_start_x       <= {`ITR_X_W{1'b0}};
			image_start_y       <= {`ITR_Y_W{1'b0}};
			flash_start_address <= {`ITR_FA_W{1'b0}};
			image_pixel_width   <= {`ITR_PW_W{1'b0}};
			image_line_count    <= {`ITR_LC_W{1'b0}};
		end else begin
			if (hi_hit(cpu_addr, `ITR_PAL_GB_ADDR)) begin
				green_nibble <= hi_byte[7:4];
				blue_nibble  <= hi_byte[3:0];
			end
			if (lo_hit(cpu_addr, `ITR_PAL_GB_ADDR))
				red_nibble <= lo_byte[3:0];
			// bank lives in the even lane only; word data comes from D15..8
			if (hi_hit(cpu_addr, `ITR_BANK_ADDR)) begin
				bank_out_top <= hi_byte[`ITR_BANK_HI];
				bank_out_mid <= hi_byte[`ITR_BANK_HI - 1];
				bank_out_low <= hi_byte[`ITR_BANK_LO];
			end
			if (hi_hit(cpu_addr, `ITR_X_ADDR))
				image_start_x[10:8] <= hi_byte[2:0];
			if (lo_hit(cpu_addr, `ITR_X_ADDR))
				image_start_x[7:0] <= lo_byte;
			if (hi_hit(cpu_addr, `ITR_Y_ADDR))
				image_start_y[9:8] <= hi_byte[1:0];
			if (lo_hit(cpu_addr, `ITR_Y_ADDR))
				image_start_y[7:0] <= lo_byte;
			// two halves written separately by the cpu
			if (hi_hit(cpu_addr, `ITR_FA_HI_ADDR))
				flash_start_address[24] <= hi_byte[0];
			if (lo_hit(cpu_addr, `ITR_FA_HI_ADDR))
				flash_start_address[23:16] <= lo_byte;
			if (hi_hit(cpu_addr, `ITR_FA_LO_ADDR))
				flash_start_address[15:8] <= hi_byte;
			if (lo_hit(cpu_addr, `ITR_FA_LO_ADDR))
				flash_start_address[7:0] <= lo_byte;
			if (hi_hit(cpu_addr, `ITR_W_ADDR))
				image_pixel_width[11:8] <= hi_byte[3:0];
			if (lo_hit(cpu_addr, `ITR_W_ADDR))
				image_pixel_width[7:0] <= lo_byte;
			if (hi_hit(cpu_addr, `ITR_LINES_ADDR))
				image_line_count[10:8] <= hi_byte[2:0];
			if (lo_hit(cpu_addr, `ITR_LINES_ADDR))
				image_line_count[7:0] <= lo_byte;
		end
	end

	// ****************************************
	// start command decode
	// ****************************************
	// go bit sits in the odd lane (bit 0 of the low byte)
	// a zero written to it is simply ignored
	wire go_write = lo_hit(cpu_addr, `ITR_CTRL_ADDR) && lo_byte[`ITR_GO_BIT];

	// ****************************************
	// transfer handshake
	// ****************************************
	// go is ignored while a transfer is already in flight
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg      <= ST_IDLE;
			pulse_reg      <= 16'h0000;
			go_reg         <= 1'b0;
			transfer_go    <= 1'b0;
			bus_req        <= 1'b0;
			xfer_run       <= 1'b0;
			done_irq_out_n <= 1'b1;
		end else begin
			transfer_go <= 1'b0;
			case (state_reg)
			// a go write only counts here; later ones are dropped
			ST_IDLE: begin
				done_irq_out_n <= 1'b1;
				if (go_write) begin
					go_reg    <= 1'b1;
					bus_req   <= 1'b1;
					state_reg <= ST_REQ;
				end
			end
			// nothing touches the flash until the cpu has let go of the bus
			ST_REQ: begin
				if (bus_grant) begin
					go_reg      <= 1'b0;
					transfer_go <= 1'b1;
					xfer_run    <= 1'b1;
					state_reg   <= ST_RUN;
				end
			end
			// the engine reports its own end; no line or pixel count here
			ST_RUN: begin
				if (xfer_done) begin
					xfer_run       <= 1'b0;
					bus_req        <= 1'b0;
					done_irq_out_n <= 1'b0;
					pulse_reg      <= PULSE_CYC[15:0] - 16'h0001;
					state_reg      <= ST_DONE;
				end
			end
			// pulse low for PULSE_CYC cycles; the load above already
			// took one, so the count runs down to zero before release
			ST_DONE: begin
				if (pulse_reg == 16'h0000) begin
					done_irq_out_n <= 1'b1;
					state_reg      <= ST_IDLE;
				end else begin
					pulse_reg <= pulse_reg - 16'h0001;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

endmodule // itr_setup_regs

// ### itr_setup_regs_chk_sva.sv
`timescale 1ns/100ps
// watches the bank, start X and transfer handshake ports only; widths follow the design
module itr_setup_regs_chk #(
	parameter PULSE_CYC = 2
) (
	input logic        clk,
	input logic        resetn,
	input logic [22:0] cpu_addr,
	input logic [15:0] cpu_wdata,
	input logic        cpu_wr,
	input logic        cpu_word,
	input logic        bus_grant,
	input logic        xfer_done,
	input logic        bank_out_top,
	input logic        bank_out_mid,
	input logic        bank_out_low,
	input logic [10:0] image_start_x,
	input logic        transfer_go,
	input logic        bus_req,
	input logic        xfer_run,
	input logic        done_irq_out_n
);
	reg [7:0] low_cnt_reg;
	wire [2:0] bank = {bank_out_top, bank_out_mid, bank_out_low};
	wire bank_wr = cpu_wr && cpu_addr == 23'h7fffc0;
	wire go_wr = cpu_wr && !cpu_word && cpu_addr == 23'h7fffcf && cpu_wdata[0];
	// counts low cycles of the done pulse; a counter keeps the width check cheap
	always @(posedge clk or negedge resetn)
		if (!resetn) low_cnt_reg <= 8'h00;
		else low_cnt_reg <= done_irq_out_n ? 8'h00 : low_cnt_reg + 8'h01;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_bank_word: assert property (bank_wr && cpu_word |=>
		bank == $past(cpu_wdata[13:11])) else $error("bank word lane");
	a_bank_byte: assert property (bank_wr && !cpu_word |=>
		bank == $past(cpu_wdata[5:3])) else $error("bank byte lane");
	a_x_word: assert property (cpu_wr && cpu_word && cpu_addr == 23'h7fffc2 |=>
		image_start_x == $past(cpu_wdata[10:0])) else $error("x word");
	a_x_low_byte: assert property (cpu_wr && !cpu_word && cpu_addr == 23'h7fffc3 |=>
		image_start_x == {$past(image_start_x[10:8]), $past(cpu_wdata[7:0])}) else $error("x byte");
	a_go_request: assert property (go_wr && !bus_req && done_irq_out_n
		&& $past(done_irq_out_n) |=> bus_req) else $error("go ignored");
	a_go_after_grant: assert property (transfer_go |-> $past(bus_grant) && bus_req)
		else $error("go without grant");
	a_done_release: assert property (xfer_done && xfer_run |=>
		!bus_req && !xfer_run && !done_irq_out_n) else $error("done not released");
	a_pulse_width: assert property ($rose(done_irq_out_n) |-> low_cnt_reg == PULSE_CYC)
		else $error("done pulse width");
	c_go: cover property (transfer_go);
	c_pulse: cover property ($rose(done_irq_out_n));
	c_word: cover property (cpu_wr && cpu_word);
	c_grant_wait: cover property (bus_req && !bus_grant ##1 bus_req && !bus_grant);
endmodule // itr_setup_regs_chk

// ### itr_host_model.sv
`timescale 1ns/100ps
// host side: grants the bus after a delay, then reports the transfer finished
module itr_host_model (
	input logic  clk,
	input logic  resetn,
	input logic  slow,
	input logic  bus_req,
	output logic bus_grant,
	output logic xfer_done
);
	logic [7:0] cnt_reg;
	// slow mode stalls the grant so the device must really wait for it
	always @(posedge clk or negedge resetn)
		if (!resetn) begin
			cnt_reg <= 8'h00;
			bus_grant <= 1'b0;
			xfer_done <= 1'b0;
		end else begin
			cnt_reg <= bus_req ? cnt_reg + 8'h01 : 8'h00;
			bus_grant <= bus_req && cnt_reg >= (slow ? 8'h06 : 8'h01);
			xfer_done <= bus_req && cnt_reg == (slow ? 8'h0c : 8'h05);
		end
endmodule // itr_host_model

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
	logic clk, resetn, cpu_wr, cpu_word, slow, bus_grant, xfer_done;
	logic [22:0] cpu_addr;
	logic [15:0] cpu_wdata;
	logic [3:0] green_nibble, blue_nibble, red_nibble;
	logic bank_out_top, bank_out_mid, bank_out_low;
	logic [10:0] image_start_x;
	logic [9:0] image_start_y;
	logic [24:0] flash_start_address;
	logic [11:0] image_pixel_width;
	logic [10:0] image_line_count;
	logic transfer_go, bus_req, xfer_run, done_irq_out_n;
	int mismatches = 0, tests_run = 0;
	itr_setup_regs #(.PULSE_CYC(2)) itr_setup_regs_i (
		.clk(clk), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_wr(cpu_wr), .cpu_word(cpu_word), .bus_grant(bus_grant), .xfer_done(xfer_done),
		.green_nibble(green_nibble), .blue_nibble(blue_nibble), .red_nibble(red_nibble),
		.bank_out_top(bank_out_top), .bank_out_mid(bank_out_mid),
		.bank_out_low(bank_out_low), .image_start_x(image_start_x),
		.image_start_y(image_start_y), .flash_start_address(flash_start_address),
		.image_pixel_width(image_pixel_width), .image_line_count(image_line_count),
		.transfer_go(transfer_go), .bus_req(bus_req), .xfer_run(xfer_run),
		.done_irq_out_n(done_irq_out_n));
	itr_host_model itr_host_model_i (.clk(clk), .resetn(resetn), .slow(slow),
		.bus_req(bus_req), .bus_grant(bus_grant), .xfer_done(xfer_done));
	// free-running 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task chk(input string n, input logic [24:0] e, g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// one write strobe; the gap cycle avoids driving cpu_wr twice in one step
	task wr(input logic [22:0] a, input logic [15:0] d, input logic w);
		@(negedge clk);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_word = w;
		cpu_wr = 1'b1;
		@(negedge clk);
		cpu_wr = 1'b0;
	endtask
	task t_regs;
		chk("x reset", 25'h0, itr_setup_regs_i.image_start_x);
		chk("fa reset", 25'h0, itr_setup_regs_i.flash_start_address);
		wr(23'h7fffc2, 16'hffff, 1'b1);
		wr(23'h7fffc2, 16'h0002, 1'b0);
		wr(23'h7fffd1, 16'h0000, 1'b0);
		wr(23'h7fffc3, 16'h0055, 1'b1);
		chk("x", 25'h2ff, itr_setup_regs_i.image_start_x);
		wr(23'h7fffc4, 16'h0003, 1'b0);
		wr(23'h7fffc5, 16'h00ff, 1'b0);
		chk("y", 25'h3ff, itr_setup_regs_i.image_start_y);
		wr(23'h7fffc6, 16'hffff, 1'b1);
		wr(23'h7fffc8, 16'hffff, 1'b1);
		chk("fa", 25'h1ffffff, itr_setup_regs_i.flash_start_address);
		wr(23'h7fffca, 16'hffff, 1'b1);
		wr(23'h7fffcc, 16'hffff, 1'b1);
		chk("width", 25'hfff, itr_setup_regs_i.image_pixel_width);
		chk("lines", 25'h7ff, itr_setup_regs_i.image_line_count);
		wr(23'h7fffc0, 16'h2800, 1'b1);
		chk("bank word", 25'h5, {itr_setup_regs_i.bank_out_top, itr_setup_regs_i.bank_out_mid,
			itr_setup_regs_i.bank_out_low});
		wr(23'h7fff7e, 16'h00a5, 1'b0);
		wr(23'h7fff7f, 16'h000c, 1'b0);
		chk("palette", 25'ha5c, {itr_setup_regs_i.green_nibble, itr_setup_regs_i.blue_nibble,
			itr_setup_regs_i.red_nibble});
		$display("register test done");
	endtask
	task t_xfer(input logic s);
		int n;
		slow = s;
		wr(23'h7fffcf, 16'h0000, 1'b0);
		chk("idle", 25'h0, itr_setup_regs_i.bus_req);
		wr(23'h7fffcf, 16'h0001, 1'b0);
		chk("req", 25'h1, itr_setup_regs_i.bus_req);
		for (n = 0; n < 40 && itr_setup_regs_i.transfer_go !== 1'b1; n++) @(negedge clk);
		chk("go", 25'h1, bus_grant);
		chk("run", 25'h1, xfer_run);
		for (n = 0; n < 40 && itr_setup_regs_i.done_irq_out_n !== 1'b0; n++) @(negedge clk);
		chk("req off", 25'h0, itr_setup_regs_i.bus_req);
		chk("run off", 25'h0, xfer_run);
		for (n = 0; n < 40 && itr_setup_regs_i.done_irq_out_n !== 1'b1; n++) @(negedge clk);
		chk("pulse", 25'h2, n);
		repeat (3) @(negedge clk);
		$display("transfer test done");
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// reset for four cycles, then the tests in order
	initial begin
		resetn = 1'b0;
		cpu_wr = 1'b0;
		cpu_word = 1'b0;
		cpu_addr = 23'h0;
		cpu_wdata = 16'h0;
		slow = 1'b0;
		repeat (4) @(negedge clk);
		resetn = 1'b1;
		t_regs;
		t_xfer(1'b0);
		t_xfer(1'b1);
		finish_test;
	end
	// watchdog: the tests need a few hundred cycles at most
	initial begin
		#200000;
		mismatches++;
		finish_test;
	end
endmodule // testbench
bind itr_setup_regs itr_setup_regs_chk #(.PULSE_CYC(PULSE_CYC)) itr_setup_regs_chk_i (
	.clk(clk), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
	.cpu_wr(cpu_wr), .cpu_word(cpu_word), .bus_grant(bus_grant), .xfer_done(xfer_done),
	.bank_out_top(bank_out_top), .bank_out_mid(bank_out_mid), .bank_out_low(bank_out_low),
	.image_start_x(image_start_x), .transfer_go(transfer_go), .bus_req(bus_req),
	.xfer_run(xfer_run), .done_irq_out_n(done_irq_out_n));
